// ==== logic/sfcc_pkg.sv ====
package sfcc_pkg;
  // Frame lengths in serial clock edges, and the bit counter width
  localparam int unsigned SFCC_WORD_BITS  = 16;
  localparam int unsigned SFCC_CRC_BITS   = 8;
  localparam int unsigned SFCC_FRAME_BITS = 24;
  localparam int unsigned SFCC_CNT_W      = 5;
  // CRC generator x^8 + x^2 + x + 1, register starts at zero
  localparam logic [7:0]  SFCC_CRC_POLY   = 8'h07;
  localparam logic [7:0]  SFCC_CRC_INIT   = 8'h00;
  // Interface-error flag position in the status word
  localparam int unsigned SFCC_ERR_BIT    = 3;
  localparam logic [15:0] SFCC_WORD_RST   = 16'h0000;

  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } sfcc_write_t;

  typedef enum logic [1:0] {
    SFCC_IDLE  = 2'b00,
    SFCC_SHIFT = 2'b01,
    SFCC_CHECK = 2'b10
  } sfcc_state_t;
endpackage

// ==== logic/sfcc_crc8_step.sv ====
`timescale 1ns/1ps
// One serial step of the check sequence, MSB first
module sfcc_crc8_step
  import sfcc_pkg::*;
(
  // Current remainder and incoming bit
  input  wire logic [7:0] crc_in,
  input  wire logic       bit_in,
  // Updated remainder
  output logic      [7:0] crc_out
);
  logic fb;
  always_comb begin
    fb = crc_in[7] ^ bit_in;
    crc_out = {crc_in[6:0], 1'b0} ^ (fb ? SFCC_CRC_POLY : 8'h00);
  end
endmodule

// ==== logic/sfcc_checker.sv ====
`timescale 1ns/1ps
// Contract
// - A 24-bit frame is checked when frame select rises.
// - A passing check commits the data word to its register.
// - A failing check drives fault low and sets status bit D3.
// - A status read clears the error flag and releases fault.
// - 16-bit word, each bit sampled on serial clock falling edge.
// - Link uses serial clock, data input and active-low frame select.
// - Error flag is set only by a CRC-8 mismatch.
// - Fault is a single open-drain active-low output.
module sfcc_checker
  import sfcc_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Serial link pins
  input  wire logic        sclk,
  input  wire logic        sdin,
  input  wire logic        sync_n,
  // Status read strobe from the register logic
  input  wire logic        status_read,
  // Committed write toward the register file
  output sfcc_write_t      wr,
  // Status flag and open-drain fault pin
  output logic             interface_crc_error_flag,
  output logic             fault_o,
  output logic             fault_oe
);
  // Pin synchronisers; the first stage feeds only the second
  logic [1:0] sclk_s, sdin_s, sync_s;
  logic       sclk_d, sync_d;
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sclk_s <= 2'b11;
      sdin_s <= 2'b00;
      sync_s <= 2'b11;
      sclk_d <= 1'b1;
      sync_d <= 1'b1;
    end else begin
      sclk_s <= {sclk_s[0], sclk};
      sdin_s <= {sdin_s[0], sdin};
      sync_s <= {sync_s[0], sync_n};
      sclk_d <= sclk_s[1];
      sync_d <= sync_s[1];
    end
  end

  logic fall, sync_rise, sync_fall;
  assign fall      = sclk_d & ~sclk_s[1] & ~sync_s[1];
  assign sync_rise = ~sync_d & sync_s[1];
  assign sync_fall = sync_d & ~sync_s[1];

  sfcc_state_t           state, next_state;
  logic [23:0]           shreg, next_shreg;
  logic [SFCC_CNT_W-1:0] cnt, next_cnt;
  logic [7:0]            crc, next_crc, crc_upd;
  sfcc_write_t           next_wr;
  logic                  next_flag;
  logic                  set_err;

  sfcc_crc8_step u_step (
    .crc_in  (crc),
    .bit_in  (sdin_s[1]),
    .crc_out (crc_upd)
  );

  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_cnt   = cnt;
    next_crc   = crc;
    next_wr    = '{valid: 1'b0, data: wr.data};
    set_err    = 1'b0;
    unique case (state)
      SFCC_IDLE: begin
        if (sync_fall) begin
          next_state = SFCC_SHIFT;
          next_cnt   = '0;
          next_crc   = SFCC_CRC_INIT;
        end
      end
      SFCC_SHIFT: begin
        if (fall && cnt < SFCC_CNT_W'(SFCC_FRAME_BITS)) begin
          next_shreg = {shreg[22:0], sdin_s[1]};
          next_cnt   = cnt + 1'b1;
          next_crc   = crc_upd;
        end
        if (sync_rise) begin
          next_state = SFCC_CHECK;
        end
      end
      SFCC_CHECK: begin
        next_state = SFCC_IDLE;
        if (cnt == SFCC_CNT_W'(SFCC_WORD_BITS)) begin
          next_wr = '{valid: 1'b1, data: shreg[15:0]};
        end else if (cnt == SFCC_CNT_W'(SFCC_FRAME_BITS)) begin
          if (crc == SFCC_CRC_INIT) begin
            next_wr = '{valid: 1'b1, data: shreg[23:8]};
          end else begin
            set_err = 1'b1;
          end
        end
      end
      default: next_state = SFCC_IDLE;
    endcase
    // Read clears; a mismatch in the same cycle wins
    next_flag = set_err | (interface_crc_error_flag & ~status_read);
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state <= SFCC_IDLE;
      shreg <= '0;
      cnt   <= '0;
      crc   <= SFCC_CRC_INIT;
      wr    <= '{valid: 1'b0, data: SFCC_WORD_RST};
      interface_crc_error_flag <= 1'b0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      cnt   <= next_cnt;
      crc   <= next_crc;
      wr    <= next_wr;
      interface_crc_error_flag <= next_flag;
    end
  end

  // Open drain: pull low while flag set, never drive high
  assign fault_o  = 1'b0;
  assign fault_oe = interface_crc_error_flag;

  // A full frame that ends with a wrong check byte raises the flag
  property p_bad_sets;
    @(posedge core_clk) disable iff (!resetn)
      (state == SFCC_CHECK && cnt == SFCC_CNT_W'(SFCC_FRAME_BITS)
       && crc != 8'h00) |=> interface_crc_error_flag;
  endproperty
  a_bad_sets: assert property (p_bad_sets)
    else $error("bad frame did not set flag");

  property p_good_commit;
    @(posedge core_clk) disable iff (!resetn)
      (state == SFCC_CHECK && cnt == SFCC_CNT_W'(SFCC_FRAME_BITS)
       && crc == 8'h00) |=> wr.valid && wr.data == $past(shreg[23:8]);
  endproperty
  a_good_commit: assert property (p_good_commit)
    else $error("good frame not committed");

  property p_short_commit;
    @(posedge core_clk) disable iff (!resetn)
      (state == SFCC_CHECK && cnt == SFCC_CNT_W'(SFCC_WORD_BITS))
      |=> wr.valid && wr.data == $past(shreg[15:0]);
  endproperty
  a_short_commit: assert property (p_short_commit)
    else $error("16-bit frame not committed");

  property p_flag_cause;
    @(posedge core_clk) disable iff (!resetn)
      $rose(interface_crc_error_flag) |->
        $past(state) == SFCC_CHECK && $past(crc) != 8'h00;
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("flag set without crc mismatch");

  property p_read_clears;
    @(posedge core_clk) disable iff (!resetn)
      (status_read && state != SFCC_CHECK) |=> !interface_crc_error_flag;
  endproperty
  a_read_clears: assert property (p_read_clears)
    else $error("status read did not clear flag");

  property p_fault_pin;
    @(posedge core_clk) disable iff (!resetn)
      fault_oe == interface_crc_error_flag && !fault_o;
  endproperty
  a_fault_pin: assert property (p_fault_pin)
    else $error("fault pin not open drain on flag");

  property p_check_on_rise;
    @(posedge core_clk) disable iff (!resetn)
      (state == SFCC_SHIFT && sync_rise) |=> state == SFCC_CHECK
        ##1 state == SFCC_IDLE;
  endproperty
  a_check_on_rise: assert property (p_check_on_rise)
    else $error("frame end not checked");

  property p_no_commit_other;
    @(posedge core_clk) disable iff (!resetn)
      wr.valid |-> $past(state) == SFCC_CHECK;
  endproperty
  a_no_commit_other: assert property (p_no_commit_other)
    else $error("write outside frame end");

  c_good: cover property (@(posedge core_clk) disable iff (!resetn)
    wr.valid && $past(cnt) == SFCC_CNT_W'(SFCC_FRAME_BITS));
  c_short: cover property (@(posedge core_clk) disable iff (!resetn)
    wr.valid && $past(cnt) == SFCC_CNT_W'(SFCC_WORD_BITS));
  c_err: cover property (@(posedge core_clk) disable iff (!resetn)
    $rose(interface_crc_error_flag));
  c_clear: cover property (@(posedge core_clk) disable iff (!resetn)
    $fell(interface_crc_error_flag));
endmodule

// ==== tb/sfcc_host_model.sv ====
`timescale 1ns/1ps
module sfcc_host_model (
  // Pacing clock
  input  wire logic core_clk,
  // Serial link toward the device
  output logic      sclk,
  output logic      sdin,
  output logic      sync_n
);
  initial begin
    sclk = 1'b1;
    sdin = 1'b0;
    sync_n = 1'b1;
  end

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  function automatic logic [7:0] crc8(input logic [15:0] w);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  task automatic send(input logic [15:0] w, input int nbits, input logic bad);
    logic [23:0] f;
    f = {w, crc8(w) ^ {7'h00, bad}};
    wait_cyc(1);
    sync_n = 1'b0;
    for (int k = 0; k < nbits; k++) begin
      sdin = f[23-k];
      wait_cyc(2);
      sclk = 1'b0;
      wait_cyc(4);
      sclk = 1'b1;
      wait_cyc(2);
    end
    sync_n = 1'b1;
    // Released line shows no stale bit
    sdin = ~sdin;
    wait_cyc(4);
  endtask
endmodule

// ==== tb/serial_frame_crc8_checker_tb.sv ====
`timescale 1ns/1ps
module serial_frame_crc8_checker_tb;
  import sfcc_pkg::*;
  typedef struct {
    logic [15:0] w;
    int          n;
    logic        bad;
    logic        clr;
    logic        commit;
    logic        flag;
  } sfcc_row_t;
  logic        core_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        status_read = 1'b0;
  logic        sclk, sdin, sync_n, flag, fault_o, fault_oe;
  sfcc_write_t wr;
  int          bad_count = 0;
  int          num_checks = 0;
  int          commits = 0;
  int          c0;
  logic [15:0] last = 16'h0000;
  sfcc_row_t   rows [7] = '{
    '{16'h1234, 24, 1'b0, 1'b0, 1'b1, 1'b0},
    '{16'h8001, 16, 1'b0, 1'b0, 1'b1, 1'b0},
    '{16'hbeef, 24, 1'b1, 1'b0, 1'b0, 1'b1},
    '{16'h00ff, 24, 1'b0, 1'b1, 1'b1, 1'b1},
    '{16'h0abc, 12, 1'b0, 1'b0, 1'b0, 1'b0},
    '{16'hffff, 24, 1'b0, 1'b0, 1'b1, 1'b0},
    '{16'h0000, 24, 1'b1, 1'b1, 1'b0, 1'b1}};

  always #2 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (wr.valid === 1'b1) begin
      commits++;
    end
  end

  sfcc_checker i_dut (
    .core_clk                 (core_clk),
    .resetn                   (resetn),
    .sclk                     (sclk),
    .sdin                     (sdin),
    .sync_n                   (sync_n),
    .status_read              (status_read),
    .wr                       (wr),
    .interface_crc_error_flag (flag),
    .fault_o                  (fault_o),
    .fault_oe                 (fault_oe)
  );
  sfcc_host_model i_host (
    .core_clk (core_clk),
    .sclk     (sclk),
    .sdin     (sdin),
    .sync_n   (sync_n)
  );

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d errors=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #200000;
    bad_count++;
    summarize();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    chk(wr, 17'h0);
    chk({16'h0, flag}, 17'h0);
    chk({16'h0, fault_oe}, 17'h0);
    #1 resetn = 1'b1;
    for (int r = 0; r < 7; r++) begin
      c0 = commits;
      i_host.send(rows[r].w, rows[r].n, rows[r].bad);
      repeat (8) @(posedge core_clk);
      #1;
      if (rows[r].commit) begin
        last = rows[r].w;
      end
      chk(17'(commits - c0), {16'h0, rows[r].commit});
      chk({1'b0, wr.data}, {1'b0, last});
      chk({16'h0, flag}, {16'h0, rows[r].flag});
      chk({15'h0, fault_oe, fault_o}, {15'h0, rows[r].flag, 1'b0});
      if (rows[r].clr) begin
        status_read = 1'b1;
        @(posedge core_clk);
        #1 status_read = 1'b0;
        @(posedge core_clk);
        #1;
        chk({15'h0, flag, fault_oe}, 17'h0);
      end
    end
    // Set wins: a clear pulse in the check cycle of a bad frame
    c0 = commits;
    i_host.send(16'h5a5a, 24, 1'b1);
    repeat (8) @(posedge core_clk);
    #1;
    fork
      i_host.send(16'h0f0f, 24, 1'b1);
      begin
        // Frame select rises 193 edges in; check cycle 3 edges later
        repeat (196) @(posedge core_clk);
        #1 status_read = 1'b1;
        @(posedge core_clk);
        #1 status_read = 1'b0;
      end
    join
    repeat (8) @(posedge core_clk);
    #1;
    chk({16'h0, flag}, 17'h1);
    chk({16'h0, fault_oe}, 17'h1);
    chk(17'(commits - c0), 17'h0);
    chk({1'b0, wr.data}, {1'b0, last});
    // Mid-run reset drops the pending error and the last word
    resetn = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chk(wr, 17'h0);
    chk({15'h0, flag, fault_oe}, 17'h0);
    resetn = 1'b1;
    c0 = commits;
    i_host.send(16'h4321, 24, 1'b0);
    repeat (8) @(posedge core_clk);
    #1;
    chk(17'(commits - c0), 17'h1);
    chk({1'b0, wr.data}, 17'h04321);
    chk({16'h0, flag}, 17'h0);
    summarize();
  end
endmodule
